/* File: design/acr_regs.sv */
// Converter configuration registers with decoded reference, pin role, timing and clock settings.
//
// Local design decisions: strobed register access and the register addresses.
`default_nettype none
module acr_regs (
  input  wire logic                 clk_i,     // System clock.
  input  wire logic                 arst_n_i,  // Asynchronous reset, active low.
  input  wire acr_pkg::acr_bus_req_t bus_i,    // Register bus request.
  output logic [7:0]                rdata_o,   // Read data, one cycle after the strobe.
  output acr_pkg::acr_cfg_t         cfg_o      // Decoded configuration to the converter.
);

  typedef struct packed {
    logic [7:0] ref_port;
    logic [7:0] fmt_clk;
    logic [7:0] rdata;
    logic [2:0] rc_wait;
  } acr_state_t;

  acr_state_t s_q;
  acr_state_t s_d;

  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    case (code)
      3'h0:    acq_periods = 5'h00;
      3'h1:    acq_periods = 5'h02;
      3'h2:    acq_periods = 5'h04;
      3'h3:    acq_periods = 5'h06;
      3'h4:    acq_periods = 5'h08;
      3'h5:    acq_periods = 5'h0c;
      3'h6:    acq_periods = 5'h10;
      default: acq_periods = 5'h14;
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] code);
    is_rc = (code[1:0] == 2'h3);
  endfunction

  logic [3:0] pin_role;
  logic [2:0] acq_code;
  logic [2:0] clk_code;
  assign pin_role = s_q.ref_port[acr_pkg::PIN_ROLE_LSB +: 4];
  assign acq_code = s_q.fmt_clk[acr_pkg::ACQ_LSB +: 3];
  assign clk_code = s_q.fmt_clk[acr_pkg::CLK_SEL_LSB +: 3];

  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    if (bus_i.wr)
    begin
      // Masking on write keeps unimplemented bits at zero for later reads.
      if (bus_i.addr == acr_pkg::ADDR_REF_PORT)
        s_d.ref_port = bus_i.wdata & acr_pkg::REF_PORT_MASK;
      else
        s_d.fmt_clk = bus_i.wdata & acr_pkg::FMT_CLK_MASK;
    end
    if (bus_i.rd)
    begin
      if (bus_i.addr == acr_pkg::ADDR_REF_PORT)
        s_d.rdata = s_q.ref_port & acr_pkg::REF_PORT_MASK;
      else
        s_d.rdata = s_q.fmt_clk & acr_pkg::FMT_CLK_MASK;
    end
    // The start delay restarts whenever the RC source is not chosen.
    if (!is_rc(clk_code))
      s_d.rc_wait = acr_pkg::RC_START_DELAY;
    else if (s_q.rc_wait != 3'h0)
      s_d.rc_wait = s_q.rc_wait - 3'h1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q.ref_port <= acr_pkg::REF_PORT_RESET;
      s_q.fmt_clk  <= acr_pkg::FMT_CLK_RESET;
      s_q.rdata    <= 8'h00;
      s_q.rc_wait  <= acr_pkg::RC_START_DELAY;
    end
    else
      s_q <= s_d;
  end

  assign rdata_o = s_q.rdata;

  genvar ch;
  generate
    for (ch = 0; ch < acr_pkg::NUM_CHANNELS; ch++)
    begin : g_pin
      // Channel ch turns digital once the code reaches 3 + (12 - ch).
      assign cfg_o.channel_digital[ch] =
        (pin_role > acr_pkg::PIN_ROLE_ALL_AN) &&
        (5'(pin_role) >= 5'(acr_pkg::PIN_ROLE_ALL_AN) + 5'(acr_pkg::NUM_CHANNELS - ch));
    end
  endgenerate

  assign cfg_o.neg_ref_select        = s_q.ref_port[acr_pkg::NEG_REF_BIT];
  assign cfg_o.pos_ref_select        = s_q.ref_port[acr_pkg::POS_REF_BIT];
  assign cfg_o.result_justify_select = s_q.fmt_clk[acr_pkg::JUSTIFY_BIT];
  // Zero periods tells the engine to convert on start with no sampling phase.
  assign cfg_o.acq_periods           = acq_periods(acq_code);
  assign cfg_o.internal_rc_clock     = is_rc(clk_code);
  assign cfg_o.conv_clock_run        = !is_rc(clk_code) || (s_q.rc_wait == 3'h0);

  // A function keeps every field of cfg_o under continuous assignment, so no field is mixed with a process.
  function automatic logic [6:0] clk_divide(input logic [2:0] code);
    case (code)
      3'h0:    clk_divide = 7'h02;
      3'h1:    clk_divide = 7'h08;
      3'h2:    clk_divide = 7'h20;
      3'h4:    clk_divide = 7'h04;
      3'h5:    clk_divide = 7'h10;
      3'h6:    clk_divide = 7'h40;
      default: clk_divide = 7'h00;
    endcase
  endfunction

  assign cfg_o.clock_divide          = clk_divide(clk_code);

endmodule
`default_nettype wire

/* File: shared/acr_pkg.sv */
// Package for the converter configuration registers: offsets, fields, reset values and decode types.
`default_nettype none
package acr_pkg;
  localparam logic [0:0] ADDR_REF_PORT   = 1'h0;
  localparam logic [0:0] ADDR_FMT_CLK    = 1'h1;
  localparam logic [7:0] REF_PORT_MASK   = 8'h3f;
  localparam logic [7:0] FMT_CLK_MASK    = 8'hbf;
  localparam logic [7:0] REF_PORT_RESET  = 8'h00;
  localparam logic [7:0] FMT_CLK_RESET   = 8'h00;
  localparam int         NEG_REF_BIT     = 5;
  localparam int         POS_REF_BIT     = 4;
  localparam int         PIN_ROLE_LSB    = 0;
  localparam int         JUSTIFY_BIT     = 7;
  localparam int         ACQ_LSB         = 3;
  localparam int         CLK_SEL_LSB     = 0;
  localparam int         NUM_CHANNELS    = 12;
  localparam logic [3:0] PIN_ROLE_ALL_AN = 4'h3;
  // One instruction cycle is four system clocks.
  localparam logic [2:0] RC_START_DELAY  = 3'h4;

  typedef struct packed {
    logic [0:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acr_bus_req_t;

  typedef struct packed {
    logic                    neg_ref_select;
    logic                    pos_ref_select;
    logic [NUM_CHANNELS-1:0] channel_digital;
    logic                    result_justify_select;
    logic [4:0]              acq_periods;
    logic                    internal_rc_clock;
    logic [6:0]              clock_divide;
    logic                    conv_clock_run;
  } acr_cfg_t;
endpackage
`default_nettype wire

/* File: testbench/acr_regs_chk.sv */
// Port checks for the converter configuration registers.
`default_nettype none
module acr_regs_chk (
  input wire logic clk_i, // Clock.
  input wire logic arst_n_i, // Reset.
  input wire acr_pkg::acr_bus_req_t bus_i, // Bus.
  input wire logic [7:0] rdata_o, // Read data.
  input wire acr_pkg::acr_cfg_t cfg_o // Settings.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic w0 = bus_i.wr && !bus_i.addr;
  wire logic w1 = bus_i.wr && bus_i.addr;
  AST_NEG: assert property (w0 |=> cfg_o.neg_ref_select == $past(bus_i.wdata[5])) else $error("neg");
  AST_POS: assert property (w0 |=> cfg_o.pos_ref_select == $past(bus_i.wdata[4])) else $error("pos");
  AST_PIN: assert property (w0 && bus_i.wdata[3:2] == 2'h0 |=> cfg_o.channel_digital == 12'h000)
    else $error("pin");
  AST_UNU: assert property (bus_i.rd |=> rdata_o[6] == 1'h0) else $error("unu");
  AST_JUS: assert property (w1 |=> cfg_o.result_justify_select == $past(bus_i.wdata[7])) else $error("jus");
  AST_ACQ: assert property (w1 && bus_i.wdata[5:3] == 3'h7 |=> cfg_o.acq_periods == 5'h14)
    else $error("acq");
  AST_RC: assert property (cfg_o.internal_rc_clock |-> cfg_o.clock_divide == 7'h00) else $error("rc");
  AST_DIV: assert property (w1 && bus_i.wdata[2:0] == 3'h6 |=> cfg_o.clock_divide == 7'h40) else $error("div");
  AST_RUN: assert property ($rose(cfg_o.internal_rc_clock) |-> !cfg_o.conv_clock_run) else $error("run");
  cover property (bus_i.rd ##1 rdata_o != 8'h00);
  cover property ($rose(cfg_o.internal_rc_clock));
  cover property (cfg_o.channel_digital == 12'hfff);
endmodule
bind acr_regs acr_regs_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .cfg_o(cfg_o));
`default_nettype wire

/* File: testbench/acr_regs_tb.sv */
// Bench for the converter configuration registers.
`default_nettype none
module acr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, arst_n_i;
  logic [7:0] rdata_o, m [2] = '{8'h00, 8'h00};
  acr_pkg::acr_bus_req_t bus_i;
  acr_pkg::acr_cfg_t cfg_o;
  int fails = 0, n_checks = 0, acq_t [8] = '{0, 2, 4, 6, 8, 12, 16, 20}, div_t [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  acr_regs u_acr_regs (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .cfg_o(cfg_o));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    bus_i = '0;
    arst_n_i = 1'b0;
    void'($urandom(32'h35eb3cf6));
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 200; i++)
    begin
      acc(i[0], 1'b0, 8'h00);
      chk(rdata_o, m[i[0]]);
      m[i[0]] = i < 32 ? {i[4:1], i[4:1]} : 8'($urandom);
      acc(i[0], 1'b1, m[i[0]]);
      m[i[0]] &= i[0] ? 8'hbf : 8'h3f;
      chk(cfg_o.channel_digital, m[0][3:2] ? 12'(~(12'hfff >> (m[0][3:0] - 4'h3))) : 12'h000);
      chk(cfg_o.acq_periods, acq_t[m[1][5:3]]);
      chk(cfg_o.clock_divide, div_t[m[1][2:0]]);
      chk(cfg_o.neg_ref_select, m[0][5]);
      chk(cfg_o.pos_ref_select, m[0][4]);
      chk(cfg_o.result_justify_select, m[1][7]);
      chk(cfg_o.internal_rc_clock, m[1][1:0] == 2'h3);
    end
    finish_test;
  end
endmodule
`default_nettype wire
